/* i2c_register_access_port.sv */
// Purpose: Two-wire slave port giving a bus master access to registers.
// Assumes: scl_clk and scl_in are the same bus clock pin.
// Notes: reg_rdata is valid the cycle after reg_rd.
`timescale 1ns/100ps
module i2c_register_access_port (
  // Core clock, reset and clock enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Bus clock as a clock and as a sampled pin
  input wire logic scl_clk,
  input wire logic scl_in,
  // Bus data pin
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  // Port select straps
  input wire logic port_select_strap_low_bit,
  input wire logic port_select_strap_high_bit,
  // Register access
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Status
  output logic port_enabled
);

  i2c_link_if lnk ();

  i2c_link_shifter u_shifter (
    .scl_clk(scl_clk),
    .nrst(nrst),
    .sda_in(sda_in),
    .lnk(lnk)
  );

  // Incoming pin and toggle levels
  logic [5:0] pins;
  logic [5:0] s1;
  logic [5:0] s2;
  logic [5:0] s3;
  logic [5:0] filt;
  logic [5:0] filt_d;
  logic [5:0] next_filt;
  logic scl_hi;
  logic start_evt;
  logic stop_evt;
  logic rx_evt;
  logic ack_evt;

  // The bus clock is never driven, only sampled here
  assign pins = {lnk.ack_toggle, lnk.rx_toggle, sda_in, scl_in,
                 port_select_strap_high_bit, port_select_strap_low_bit};

  // A change counts once the second and third stages agree
  always_comb
  begin
    next_filt = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1 <= 6'h00;
      s2 <= 6'h00;
      s3 <= 6'h00;
      filt <= 6'h00;
      filt_d <= 6'h00;
    end
    else if (ce)
    begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      filt_d <= filt;
    end
  end

  // Pin events; data moving while clock is high frames a transfer
  assign scl_hi = filt[2] & filt_d[2];
  assign start_evt = scl_hi & filt_d[3] & ~filt[3];
  assign stop_evt = scl_hi & ~filt_d[3] & filt[3];
  assign rx_evt = filt[4] ^ filt_d[4];
  assign ack_evt = filt[5] ^ filt_d[5];

  // Strap capture after reset release
  logic [2:0] strap_cnt;
  logic [2:0] next_strap_cnt;
  logic strap_done;
  logic next_strap_done;
  logic [1:0] addr_low;
  logic [1:0] next_addr_low;
  logic next_port_enabled;
  logic [6:0] own_addr;

  always_comb
  begin
    next_strap_cnt = strap_cnt;
    next_strap_done = strap_done;
    next_addr_low = addr_low;
    next_port_enabled = port_enabled;
    if (!strap_done)
    begin
      if (strap_cnt == i2c_rap_pkg::STRAP_SETTLE_CYCLES)
      begin
        next_strap_done = 1'b1;
        next_addr_low = i2c_rap_pkg::strap_low_bits(filt[1],
                                                    filt[0]);
        next_port_enabled = filt[1] | filt[0];
      end
      else
        next_strap_cnt = strap_cnt + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_cnt <= 3'h0;
      strap_done <= 1'b0;
      addr_low <= 2'h0;
      port_enabled <= 1'b0;
    end
    else if (ce)
    begin
      strap_cnt <= next_strap_cnt;
      strap_done <= next_strap_done;
      addr_low <= next_addr_low;
      port_enabled <= next_port_enabled;
    end
  end

  assign own_addr = {i2c_rap_pkg::SLAVE_ADDR_UPPER, addr_low};

  // Byte engine and register access
  function automatic logic [15:0] next_location(input logic [15:0] a);
    return a + 16'h0001;
  endfunction

  i2c_rap_pkg::bus_state_t state;
  i2c_rap_pkg::bus_state_t next_state;
  logic [7:0] addr_hi;
  logic [7:0] next_addr_hi;
  logic [15:0] next_reg_addr;
  logic [7:0] next_reg_wdata;
  logic next_reg_wr;
  logic next_reg_rd;
  logic fetch;
  logic next_fetch;
  logic ack_en;
  logic next_ack_en;
  logic tx_en;
  logic next_tx_en;
  logic [7:0] tx_byte;
  logic [7:0] next_tx_byte;
  logic frame_clr;
  logic next_frame_clr;

  always_comb
  begin
    next_state = state;
    next_addr_hi = addr_hi;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    next_reg_wr = 1'b0;
    next_reg_rd = 1'b0;
    next_fetch = reg_rd;
    next_ack_en = ack_en;
    next_tx_en = tx_en;
    next_tx_byte = tx_byte;
    next_frame_clr = 1'b0;
    if (fetch)
      next_tx_byte = reg_rdata;
    if (reg_wr)
      next_reg_addr = next_location(reg_addr);
    if (!port_enabled)
      next_state = i2c_rap_pkg::st_idle;
    else if (start_evt)
    begin
      next_state = i2c_rap_pkg::st_addr;
      next_frame_clr = 1'b1;
    end
    else if (stop_evt)
      next_state = i2c_rap_pkg::st_idle;
    else
    begin
      unique case (state)
        i2c_rap_pkg::st_idle:
        begin
          next_state = i2c_rap_pkg::st_idle;
        end
        i2c_rap_pkg::st_addr:
        begin
          if (rx_evt)
          begin
            if (lnk.rx_byte[7:1] == own_addr)
            begin
              next_ack_en = 1'b1;
              if (lnk.rx_byte[0])
              begin
                next_reg_rd = 1'b1;
                next_state = i2c_rap_pkg::st_rdata;
              end
              else
                next_state = i2c_rap_pkg::st_reg_hi;
            end
            else
              next_state = i2c_rap_pkg::st_idle;
          end
        end
        i2c_rap_pkg::st_reg_hi:
        begin
          if (rx_evt)
          begin
            next_addr_hi = lnk.rx_byte;
            next_state = i2c_rap_pkg::st_reg_lo;
          end
        end
        i2c_rap_pkg::st_reg_lo:
        begin
          if (rx_evt)
          begin
            next_reg_addr = {addr_hi, lnk.rx_byte};
            next_state = i2c_rap_pkg::st_wdata;
          end
        end
        i2c_rap_pkg::st_wdata:
        begin
          if (rx_evt)
          begin
            next_reg_wdata = lnk.rx_byte;
            next_reg_wr = 1'b1;
          end
        end
        i2c_rap_pkg::st_rdata:
        begin
          if (ack_evt)
          begin
            if (ack_en)
            begin
              next_ack_en = 1'b0;
              next_tx_en = 1'b1;
            end
            else
            begin
              next_reg_addr = next_location(reg_addr);
              if (lnk.master_ack)
                next_reg_rd = 1'b1;
              else
                next_state = i2c_rap_pkg::st_idle;
            end
          end
        end
      endcase
    end
    if (next_state == i2c_rap_pkg::st_idle)
    begin
      next_ack_en = 1'b0;
      next_tx_en = 1'b0;
      next_frame_clr = 1'b1;
    end
    if (start_evt)
    begin
      next_ack_en = 1'b0;
      next_tx_en = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= i2c_rap_pkg::st_idle;
      addr_hi <= i2c_rap_pkg::BYTE_RESET;
      reg_addr <= i2c_rap_pkg::REG_ADDR_RESET;
      reg_wdata <= i2c_rap_pkg::BYTE_RESET;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      fetch <= 1'b0;
      ack_en <= 1'b0;
      tx_en <= 1'b0;
      tx_byte <= i2c_rap_pkg::BYTE_RESET;
      frame_clr <= 1'b1;
      sda_o <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      addr_hi <= next_addr_hi;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      reg_wr <= next_reg_wr;
      reg_rd <= next_reg_rd;
      fetch <= next_fetch;
      ack_en <= next_ack_en;
      tx_en <= next_tx_en;
      tx_byte <= next_tx_byte;
      frame_clr <= next_frame_clr;
      sda_o <= 1'b0;
    end
  end

  // Hand over to the bus-clock shifter
  assign lnk.link_nrst = nrst & ~frame_clr;
  assign lnk.ack_en = ack_en;
  assign lnk.tx_en = tx_en;
  assign lnk.tx_byte = tx_byte;
  assign sda_oe = lnk.sda_oe;

endmodule

/* i2c_rap_pkg.sv */
// Purpose: Shared constants, types and helpers of the two-wire register port.
// Assumes: A 16-bit register address space behind the port.
// Notes: Counts are in bus bit slots or core clock cycles.
package i2c_rap_pkg;

  // Fixed upper part of the slave address
  localparam logic [4:0] SLAVE_ADDR_UPPER = 5'h15;

  // Supported bus bit rates
  localparam int STANDARD_MODE_KHZ = 100;
  localparam int FAST_MODE_KHZ = 400;

  // Bit slot positions within one nine-pulse byte frame
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8;

  // Core cycles after reset release before the straps are taken
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

  // Values after reset
  localparam logic [15:0] REG_ADDR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Byte-level states of the bus engine
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_reg_hi,
    st_reg_lo,
    st_wdata,
    st_rdata
  } bus_state_t;

  // Low two slave address bits from the straps (both low means disabled)
  function automatic logic [1:0] strap_low_bits(input logic sp_hi,
                                                input logic sp_lo);
    return {sp_hi & sp_lo, sp_hi & ~sp_lo};
  endfunction

endpackage

/* i2c_link_if.sv */
// Purpose: Signals between the core-clock engine and the bus-clock shifter.
// Assumes: Words are held stable by their sender around each toggle.
// Notes: link_nrst clears the bit framing at start, stop and idle.
`timescale 1ns/100ps
interface i2c_link_if;
  logic link_nrst;
  logic [7:0] rx_byte;
  logic rx_toggle;
  logic ack_toggle;
  logic master_ack;
  logic ack_en;
  logic tx_en;
  logic [7:0] tx_byte;
  logic sda_oe;

  modport core (
    output link_nrst,
    output ack_en,
    output tx_en,
    output tx_byte,
    input rx_byte,
    input rx_toggle,
    input ack_toggle,
    input master_ack,
    input sda_oe
  );

  modport link (
    input link_nrst,
    input ack_en,
    input tx_en,
    input tx_byte,
    output rx_byte,
    output rx_toggle,
    output ack_toggle,
    output master_ack,
    output sda_oe
  );
endinterface

/* i2c_link_shifter.sv */
// Purpose: Bit engine clocked by the bus clock: shifts in, drives out.
// Assumes: Bus data is stable while the bus clock is high.
// Notes: Framing is cleared through link_nrst by the core engine.
`timescale 1ns/100ps
module i2c_link_shifter (
  // Bus clock and core reset
  input wire logic scl_clk,
  input wire logic nrst,
  // Bus data pin
  input wire logic sda_in,
  // Core engine side
  i2c_link_if.link lnk
);

  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [6:0] shift;
  logic [6:0] next_shift;
  logic [7:0] next_rx_byte;
  logic next_rx_toggle;
  logic next_ack_toggle;
  logic next_master_ack;
  logic next_sda_oe;

  // Framing: eight data pulses then the ninth acknowledge pulse
  always_comb
  begin
    next_bit_cnt = bit_cnt + 4'h1;
    next_shift = {shift[5:0], sda_in};
    if (bit_cnt == i2c_rap_pkg::BIT_ACK_SLOT)
    begin
      next_bit_cnt = i2c_rap_pkg::BIT_FIRST;
      next_shift = shift;
    end
  end

  always_ff @(posedge scl_clk or negedge lnk.link_nrst)
  begin
    if (!lnk.link_nrst)
    begin
      bit_cnt <= i2c_rap_pkg::BIT_FIRST;
      shift <= 7'h00;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
    end
  end

  // Handshake words, kept across frames
  always_comb
  begin
    next_rx_byte = lnk.rx_byte;
    next_rx_toggle = lnk.rx_toggle;
    next_ack_toggle = lnk.ack_toggle;
    next_master_ack = lnk.master_ack;
    if (bit_cnt == i2c_rap_pkg::BIT_LAST_DATA)
    begin
      next_rx_byte = {shift, sda_in};
      next_rx_toggle = ~lnk.rx_toggle;
    end
    if (bit_cnt == i2c_rap_pkg::BIT_ACK_SLOT)
    begin
      next_master_ack = ~sda_in;
      next_ack_toggle = ~lnk.ack_toggle;
    end
  end

  always_ff @(posedge scl_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lnk.rx_byte <= i2c_rap_pkg::BYTE_RESET;
      lnk.rx_toggle <= 1'b0;
      lnk.ack_toggle <= 1'b0;
      lnk.master_ack <= 1'b0;
    end
    else
    begin
      lnk.rx_byte <= next_rx_byte;
      lnk.rx_toggle <= next_rx_toggle;
      lnk.ack_toggle <= next_ack_toggle;
      lnk.master_ack <= next_master_ack;
    end
  end

  // Drive only on falling edges, recomputed for every slot
  always_comb
  begin
    if (bit_cnt == i2c_rap_pkg::BIT_ACK_SLOT)
      next_sda_oe = lnk.ack_en;
    else
      next_sda_oe = lnk.tx_en & ~lnk.tx_byte[3'h7 - bit_cnt[2:0]];
  end

  always_ff @(negedge scl_clk or negedge lnk.link_nrst)
  begin
    if (!lnk.link_nrst)
      lnk.sda_oe <= 1'b0;
    else
      lnk.sda_oe <= next_sda_oe;
  end

endmodule

/* i2c_bus_master.sv */
// Purpose: Behavioural two-wire bus master facing the port.
// Assumes: Data line has a pull-up, so released reads high.
// Notes: Each bus clock half lasts ten link ticks.
`timescale 1ns/100ps
module i2c_bus_master (
  // Link tick clock
  input wire logic lclk,
  // Bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // Data moves mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    tk(5);
    sda_drv = b;
    tk(5);
    scl = 1'b1;
    tk(5);
    r = sda_line;
    tk(5);
    scl = 1'b0;
  endtask
  task automatic start;
    tk(5);
    sda_drv = 1'b1;
    tk(5);
    scl = 1'b1;
    tk(5);
    sda_drv = 1'b0;
    tk(5);
    scl = 1'b0;
  endtask
  // Clock left high after stop
  task automatic stop;
    tk(5);
    sda_drv = 1'b0;
    tk(5);
    scl = 1'b1;
    tk(5);
    sda_drv = 1'b1;
    tk(5);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule

/* i2c_register_access_port_assertions.sv */
// Purpose: Port timing checks on the two-wire register port.
// Assumes: Straps only change while reset is held.
// Notes: Sees top-level ports only.
`timescale 1ns/100ps
module i2c_rap_checker (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Bus pins
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Straps
  input wire logic port_select_strap_low_bit,
  input wire logic port_select_strap_high_bit,
  // Register access
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Status
  input wire logic port_enabled
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  property p_slot;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_slot: assert property (p_slot)
    else $error("data output moved while bus clock high");
  property p_pull;
    !sda_o;
  endproperty
  a_pull: assert property (p_pull)
    else $error("data output drives high");
  property p_hold;
    $rose(sda_oe) |-> !scl_in ##1 sda_oe[*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("data pull too short");
  property p_strap;
    port_enabled |->
      (port_select_strap_low_bit || port_select_strap_high_bit);
  endproperty
  a_strap: assert property (p_strap)
    else $error("port enabled with both straps low");
  property p_off;
    !port_enabled |-> !sda_oe && !reg_wr && !reg_rd;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled port active");
  property p_incr;
    reg_wr |=> reg_addr == $past(reg_addr) + 16'h1;
  endproperty
  a_incr: assert property (p_incr)
    else $error("held address not advanced after write");
  property p_wgap;
    reg_wr |=> (!reg_wr && !reg_rd)[*8];
  endproperty
  a_wgap: assert property (p_wgap)
    else $error("write pulse too close");
  property p_rgap;
    reg_rd |=> (!reg_rd && !reg_wr)[*8];
  endproperty
  a_rgap: assert property (p_rgap)
    else $error("read pulse too close");
endmodule

/* i2c_register_access_port_tb.sv */
// Purpose: Self-checking bench of the two-wire register port.
// Assumes: Bus master model in i2c_bus_master.
// Notes: Register file modelled here, 256 entries.
`timescale 1ns/100ps
module i2c_register_access_port_tb;
  logic core_clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst, ce, sp_lo, sp_hi, scl, sda_drv, sda_line;
  logic sda_o, sda_oe, reg_wr, reg_rd, port_enabled;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rb;
  logic [7:0] mem [256];
  logic ack;
  logic [6:0] dev;
  int err_count = 0;
  int tests_run = 0;
  int wcnt = 0;
  always #20 core_clk = ~core_clk;
  initial
  begin
    #13;
    forever #40 lclk = ~lclk;
  end
  assign sda_line = sda_drv & ~sda_oe;
  i2c_bus_master u_m (.lclk(lclk), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv));
  i2c_register_access_port u_dut (.core_clk(core_clk), .nrst(nrst),
    .ce(ce), .scl_clk(scl), .scl_in(scl), .sda_in(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .port_select_strap_low_bit(sp_lo),
    .port_select_strap_high_bit(sp_hi), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_enabled(port_enabled));
  always @(negedge core_clk)
  begin
    if (reg_wr === 1'b1)
    begin
      mem[reg_addr[7:0]] <= reg_wdata;
      wcnt <= wcnt + 1;
    end
    if (reg_rd === 1'b1)
      reg_rdata <= mem[reg_addr[7:0]];
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] k);
    @(negedge core_clk);
    nrst = 1'b0;
    ce = 1'b0;
    sp_hi = k[1];
    sp_lo = k[0];
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    repeat (12) @(negedge core_clk);
    chk(port_enabled, 1'b0);
    ce = 1'b1;
    repeat (20) @(negedge core_clk);
  endtask
  task automatic open_wr(input logic [15:0] a);
    u_m.start();
    u_m.put({dev, 1'b0}, ack);
    chk(ack, 1'b1);
    u_m.put(a[15:8], ack);
    chk(ack, 1'b1);
    u_m.put(a[7:0], ack);
    chk(ack, 1'b1);
  endtask
  task automatic t_straps;
    logic [1:0] ord [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    foreach (ord[i])
    begin
      do_reset(ord[i]);
      chk(port_enabled, ord[i] != 2'h0);
      dev = (ord[i] == 2'h0) ? 7'h54 : {5'h15, ord[i] - 2'h1};
      u_m.start();
      u_m.put({dev, 1'b0}, ack);
      chk(ack, ord[i] != 2'h0);
      u_m.start();
      u_m.put({dev ^ 7'h03, 1'b0}, ack);
      chk(ack, 1'b0);
      u_m.put(8'h00, ack);
      chk(ack, 1'b0);
      u_m.stop();
    end
  endtask
  task automatic t_write;
    int w0;
    w0 = wcnt;
    open_wr(16'h12fe);
    chk(reg_addr, 16'h12fe);
    for (int i = 1; i <= 3; i++)
    begin
      u_m.put(8'h11 * i[7:0], ack);
      chk(ack, 1'b1);
    end
    u_m.stop();
    chk(wcnt - w0, 32'h3);
    chk(mem[8'hfe], 8'h11);
    chk(mem[8'h00], 8'h33);
    chk(reg_addr, 16'h1301);
  endtask
  task automatic t_read;
    int w0;
    w0 = wcnt;
    open_wr(16'h0040);
    u_m.stop();
    chk(wcnt - w0, 32'h0);
    chk(reg_addr, 16'h0040);
    u_m.start();
    u_m.put({dev, 1'b1}, ack);
    chk(ack, 1'b1);
    u_m.get(1'b0, rb);
    chk(rb, 8'h40 ^ 8'h5a);
    u_m.get(1'b1, rb);
    chk(rb, 8'h41 ^ 8'h5a);
    u_m.stop();
    chk(reg_addr, 16'h0042);
  endtask
  task automatic t_combined;
    open_wr(16'h007f);
    u_m.start();
    u_m.put({dev, 1'b1}, ack);
    chk(ack, 1'b1);
    u_m.get(1'b0, rb);
    chk(rb, 8'h7f ^ 8'h5a);
    u_m.get(1'b1, rb);
    chk(rb, 8'h80 ^ 8'h5a);
    u_m.stop();
  endtask
  task automatic t_abort;
    int w0;
    w0 = wcnt;
    open_wr(16'h0090);
    u_m.put(8'h77, ack);
    for (int i = 0; i < 4; i++)
      u_m.bit_io(1'b0, ack);
    u_m.start();
    u_m.put({dev, 1'b1}, ack);
    chk(ack, 1'b1);
    u_m.get(1'b1, rb);
    chk(rb, 8'h91 ^ 8'h5a);
    u_m.stop();
    chk(wcnt - w0, 32'h1);
    chk(mem[8'h90], 8'h77);
    u_m.start();
    u_m.put({dev, 1'b0}, ack);
    for (int i = 0; i < 4; i++)
      u_m.bit_io(1'b1, ack);
    u_m.stop();
    chk(reg_addr, 16'h0092);
  endtask
  initial
  begin
    nrst = 1'b0;
    sp_lo = 1'b1;
    sp_hi = 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ 8'h5a;
    t_straps();
    t_write();
    t_read();
    t_combined();
    t_abort();
    give_verdict();
  end
  initial
  begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end
endmodule
bind i2c_register_access_port i2c_rap_checker u_chk (
  .core_clk(core_clk), .nrst(nrst), .ce(ce), .scl_clk(scl_clk),
  .scl_in(scl_in), .sda_in(sda_in), .sda_o(sda_o), .sda_oe(sda_oe),
  .port_select_strap_low_bit(port_select_strap_low_bit),
  .port_select_strap_high_bit(port_select_strap_high_bit),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_enabled(port_enabled));
